/* src/tfm_consts.vh */
/*
 * constants for the temperature fault manager: command codes, field
 * positions, reset values and timing counts.
 * assumes a 200 MHz ref_clk; included by bare name.
 */
`ifndef TFM_CONSTS_VH
`define TFM_CONSTS_VH

// command codes of the paged management commands
`define TFM_CMD_OT_FAULT_LIM   8'h4F
`define TFM_CMD_OT_RESP        8'h50
`define TFM_CMD_OT_WARN        8'h51
`define TFM_CMD_UT_FAULT_LIM   8'h53
`define TFM_CMD_STATUS_TEMP    8'h7D
`define TFM_PAGE_ONLY          8'h00

// reset values
`define TFM_RST_OT_RESP        8'hBC
`define TFM_RST_OT_FAULT_LIM   16'h007D
`define TFM_RST_OT_WARN        16'h006E
`define TFM_RST_UT_FAULT_LIM   16'hFFD8

// response field positions
`define TFM_ACT_HI             7
`define TFM_ACT_LO             6
`define TFM_RETRY_HI           5
`define TFM_RETRY_LO           3
`define TFM_DELAY_HI           2
`define TFM_DELAY_LO           0
`define TFM_ACT_CONTINUE       2'h0
`define TFM_ACT_DISABLE        2'h2
`define TFM_RETRY_NONE         3'h0
`define TFM_RETRY_FOREVER      3'h7
`define TFM_DELAY_MAX_CODE     3'h7

// status bit positions
`define TFM_ST_OT_FAULT        7
`define TFM_ST_OT_WARN         6
`define TFM_ST_UT_FAULT        4

// hysteresis and timing
`define TFM_HYST_DEG           16'h0005
`define TFM_CLK_MHZ            200
`define TFM_MS_CYCLES          (`TFM_CLK_MHZ * 1000)
`define TFM_RETRY_STEP_MS      25
`define TFM_RETRY_MAX_MS       175

`endif

/* src/tfm_temp_fault.v */
/*
 * temperature fault manager: holds over-temperature response, fault,
 * warning and under-temperature thresholds, compares each temperature
 * sample and drives the alert pin and output enable with timed retry.
 * assumes a register port from the management-bus engine on ref_clk,
 * samples and run commands from same-clock logic.
 */
// Contract
// [RQ1] over-temp fault clears only when temperature is 5 C below threshold.
// [RQ2] action 00 continues regulation; 10 disables output and applies retry.
// [RQ3] any over-temp fault pulls alert low and sets status bit.
// [RQ4] retry 000 keeps output off until rail restarted.
// [RQ5] retry 111 restarts endlessly until commanded off or other fault.
// [RQ6] restart spacing: 000 none, 25 ms per count, 111 gives 175 ms.
// [RQ7] warning threshold 16-bit unsigned, 1 C per count, compared directly; the code compares it as signed.
// [RQ8] under-temp threshold signed 16-bit, 1 C per count.
// [RQ9] commands are paged; only page 0x00 reaches the single output.
// [RQ10] over-temp fault threshold 16-bit, default 125 C.
// [RQ11] fault or warning when sample exceeds threshold; under-temp when below.
`timescale 1ns/1ps
`include "tfm_consts.vh"

module tfm_temp_fault #(
	parameter MS_CYCLES = `TFM_MS_CYCLES
) (
	// clock and reset
	input  wire        ref_clk,
	input  wire        sys_rst,
	// register port from bus engine
	input  wire        reg_wr,
	input  wire        reg_rd,
	input  wire [7:0]  reg_page,
	input  wire [7:0]  reg_cmd,
	input  wire [15:0] reg_wdata,
	output reg  [15:0] reg_rdata,
	output reg         reg_ack,
	output reg         reg_nack,
	// status clear from bus engine
	input  wire        clear_faults,
	// temperature samples
	input  wire        temp_valid,
	input  wire [15:0] temp_sample,
	// rail control
	input  wire        rail_on_cmd,
	input  wire        other_fault_off,
	output wire        output_enable,
	output wire        alert_output_n,
	output wire [7:0]  temp_status
);

	localparam ST_IDLE  = 2'h0;
	localparam ST_RUN   = 2'h1;
	localparam ST_WAIT  = 2'h2;
	localparam ST_LATCH = 2'h3;

	reg  [7:0]  resp_r;
	reg  [15:0] ot_lim_r;
	reg  [15:0] warn_r;
	reg  [15:0] ut_lim_r;
	reg         ot_act_r;
	reg         warn_act_r;
	reg         ut_act_r;
	reg  [7:0]  stat_r;
	reg  [1:0]  state_r;
	reg  [1:0]  state_nxt;
	reg  [31:0] ms_cnt_r;
	reg  [7:0]  ms_left_r;
	reg         alert_r;
	wire        ms_tick;
	wire        page_ok;
	wire        ot_hit;
	wire        ot_clr;
	wire        ot_new;
	wire [15:0] ot_clr_lvl;

	// retry delay in ms from the delay field
	function [7:0] delay_ms;
		input [2:0]  code;
		reg   [31:0] prod;
		begin
			if (code == `TFM_DELAY_MAX_CODE)
				prod = `TFM_RETRY_MAX_MS;
			else
				prod = code * `TFM_RETRY_STEP_MS;
			// largest value is 175, so the low byte holds it whole
			delay_ms = prod[7:0];
		end
	endfunction

	////////////////////////////////////////////////////////////////////
	// register access

	// [RQ9] page check
	assign page_ok = (reg_page == `TFM_PAGE_ONLY);

	// [RQ7] [RQ8] [RQ10] threshold storage, writes on page 0 only
	always @(posedge ref_clk) begin
		if (sys_rst) begin
			resp_r   <= `TFM_RST_OT_RESP;
			ot_lim_r <= `TFM_RST_OT_FAULT_LIM;
			warn_r   <= `TFM_RST_OT_WARN;
			ut_lim_r <= `TFM_RST_UT_FAULT_LIM;
		end else if (reg_wr && page_ok) begin
			case (reg_cmd)
				`TFM_CMD_OT_RESP:      resp_r   <= reg_wdata[7:0];
				`TFM_CMD_OT_FAULT_LIM: ot_lim_r <= reg_wdata;
				`TFM_CMD_OT_WARN:      warn_r   <= reg_wdata;
				`TFM_CMD_UT_FAULT_LIM: ut_lim_r <= reg_wdata;
				default: ;
			endcase
		end
	end

	// read data and ack one cycle after request; wrong page, or unknown code on a read, nacks
	always @(posedge ref_clk) begin
		if (sys_rst) begin
			reg_rdata <= 16'h0000;
			reg_ack   <= 1'b0;
			reg_nack  <= 1'b0;
		end else begin
			reg_ack  <= 1'b0;
			reg_nack <= 1'b0;
			if (reg_wr || reg_rd) begin
				reg_ack  <= page_ok;
				reg_nack <= ~page_ok;
				if (reg_rd && page_ok) begin
					case (reg_cmd)
						`TFM_CMD_OT_RESP:      reg_rdata <= {8'h00, resp_r};
						`TFM_CMD_OT_FAULT_LIM: reg_rdata <= ot_lim_r;
						`TFM_CMD_OT_WARN:      reg_rdata <= warn_r;
						`TFM_CMD_UT_FAULT_LIM: reg_rdata <= ut_lim_r;
						`TFM_CMD_STATUS_TEMP:  reg_rdata <= {8'h00, stat_r};
						default: begin
							reg_rdata <= 16'h0000;
							reg_ack   <= 1'b0;
							reg_nack  <= 1'b1;
						end
					endcase
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// threshold compare

	// [RQ11] strict compare against each limit
	assign ot_hit     = temp_valid && ($signed(temp_sample) > $signed(ot_lim_r));
	// [RQ1] clear level is threshold minus hysteresis
	assign ot_clr_lvl = ot_lim_r - `TFM_HYST_DEG;
	assign ot_clr     = temp_valid && ($signed(temp_sample) <= $signed(ot_clr_lvl));
	assign ot_new     = ot_hit && !ot_act_r;

	// active conditions; warn and under-temp clear without hysteresis
	always @(posedge ref_clk) begin
		if (sys_rst) begin
			ot_act_r   <= 1'b0;
			warn_act_r <= 1'b0;
			ut_act_r   <= 1'b0;
		end else if (temp_valid) begin
			// [RQ1] held until hysteresis band is left
			if (ot_hit)
				ot_act_r <= 1'b1;
			else if (ot_clr)
				ot_act_r <= 1'b0;
			// [RQ7] warning uses limit directly
			warn_act_r <= ($signed(temp_sample) > $signed(warn_r));
			// [RQ8] signed under-temp compare
			ut_act_r   <= ($signed(temp_sample) < $signed(ut_lim_r));
		end
	end

	// [RQ3] sticky status and alert; a new over-temp event beats the clear
	always @(posedge ref_clk) begin
		if (sys_rst) begin
			stat_r  <= 8'h00;
			alert_r <= 1'b0;
		end else begin
			if (clear_faults) begin
				stat_r  <= 8'h00;
				alert_r <= 1'b0;
			end
			if (ot_act_r || ot_new) begin
				stat_r[`TFM_ST_OT_FAULT] <= 1'b1;
				alert_r <= 1'b1;
			end
			if (warn_act_r) begin
				stat_r[`TFM_ST_OT_WARN] <= 1'b1;
				alert_r <= 1'b1;
			end
			if (ut_act_r) begin
				stat_r[`TFM_ST_UT_FAULT] <= 1'b1;
				alert_r <= 1'b1;
			end
		end
	end

	assign alert_output_n = ~alert_r;
	assign temp_status    = stat_r;

	////////////////////////////////////////////////////////////////////
	// output control and retry

	// [RQ6] millisecond enable pulse from divider
	always @(posedge ref_clk) begin
		if (sys_rst || ms_tick)
			ms_cnt_r <= 32'h0;
		else
			ms_cnt_r <= ms_cnt_r + 32'h1;
	end
	assign ms_tick = (ms_cnt_r == MS_CYCLES - 1);

	// rail state machine
	always @* begin
		state_nxt = state_r;
		case (state_r)
			ST_IDLE:
				if (rail_on_cmd && !other_fault_off)
					state_nxt = ST_RUN;
			ST_RUN:
				if (!rail_on_cmd || other_fault_off)
					state_nxt = ST_IDLE;
				// [RQ2] only action 10 disables; 00 and unsupported codes keep running
				else if (ot_new && resp_r[`TFM_ACT_HI:`TFM_ACT_LO] == `TFM_ACT_DISABLE)
					// [RQ4] [RQ5] retry field selects latch or timed retry
					state_nxt = (resp_r[`TFM_RETRY_HI:`TFM_RETRY_LO] == `TFM_RETRY_FOREVER) ?
						ST_WAIT : ST_LATCH;
			ST_WAIT:
				// [RQ5] endless retry until commanded off or another fault
				if (!rail_on_cmd || other_fault_off)
					state_nxt = ST_IDLE;
				// [RQ6] restart once delay elapsed and fault cleared
				else if (ms_left_r == 8'h00 && !ot_act_r)
					state_nxt = ST_RUN;
			ST_LATCH:
				// [RQ4] latched off until rail is commanded off then on again
				if (!rail_on_cmd)
					state_nxt = ST_IDLE;
			default:
				state_nxt = ST_IDLE;
		endcase
	end

	// state and retry delay countdown
	always @(posedge ref_clk) begin
		if (sys_rst) begin
			state_r   <= ST_IDLE;
			ms_left_r <= 8'h00;
		end else begin
			state_r <= state_nxt;
			// [RQ6] load delay on entry to wait
			if (state_r != ST_WAIT && state_nxt == ST_WAIT)
				ms_left_r <= delay_ms(resp_r[`TFM_DELAY_HI:`TFM_DELAY_LO]);
			else if (ms_tick && ms_left_r != 8'h00)
				ms_left_r <= ms_left_r - 8'h01;
		end
	end

	assign output_enable = (state_r == ST_RUN);

endmodule

/* tb/tb_tfm_temp_fault.sv */
/* bench for tfm_temp_fault; assumes checker and host model */
`timescale 1ns/1ps
module tb_tfm_temp_fault;
	reg         ref_clk = 1'b0;
	reg         sys_rst = 1'b1;
	reg         clear_faults = 1'b0;
	reg         temp_valid = 1'b1;
	reg         rail_on_cmd = 1'b0;
	reg         other_fault_off = 1'b0;
	reg  [15:0] temp_sample = 16'h0019;
	reg  [7:0]  c;
	reg  [55:0] tab = 56'h80B8B9BF0040C0;
	wire        reg_wr, reg_rd, reg_ack, reg_nack, output_enable, alert_output_n;
	wire [7:0]  reg_page, reg_cmd, temp_status;
	wire [15:0] reg_wdata, reg_rdata;
	integer     failures = 0, cmp_count = 0, i, n, u, v, w;

	// 200 MHz clock
	always #2.5 ref_clk = ~ref_clk;

	tfm_temp_fault #(.MS_CYCLES(10)) i_tfm_temp_fault(.ref_clk, .sys_rst, .reg_wr, .reg_rd, .reg_page,
		.reg_cmd, .reg_wdata, .reg_rdata, .reg_ack, .reg_nack, .clear_faults, .temp_valid, .temp_sample,
		.rail_on_cmd, .other_fault_off, .output_enable, .alert_output_n, .temp_status);
	tfm_host_model i_tfm_host_model(.ref_clk, .reg_wr, .reg_rd, .reg_page, .reg_cmd, .reg_wdata,
		.reg_rdata, .reg_ack, .reg_nack);

	////////////////////////////////////////
	// compare on the falling edge, outputs settled
	task chk(input [15:0] s, input [15:0] e, input [39:0] nm);
		begin
			@(negedge ref_clk);
			cmp_count = cmp_count + 1;
			if (s !== e) begin
				failures = failures + 1;
				$display("BAD %0s exp %h seen %h", nm, e, s);
			end
		end
	endtask
	task cyc(input integer k);
		repeat (k) @(posedge ref_clk);
	endtask
	task wr(input [7:0] cmd, input [15:0] d);
		i_tfm_host_model.xfer(1'b1, 8'h00, cmd, d);
	endtask
	task rd(input [7:0] cmd, input [15:0] e);
		begin
			i_tfm_host_model.xfer(1'b0, 8'h00, cmd, 16'h0000);
			chk(i_tfm_host_model.rdat, e, "rdata");
		end
	endtask
	// new sample with a status clear beside it; set must win
	task tmp(input [15:0] t);
		begin
			@(posedge ref_clk);
			temp_sample <= t;
			clear_faults <= 1'b1;
			@(posedge ref_clk);
			clear_faults <= 1'b0;
			cyc(3);
		end
	endtask
	// restart spacing in cycles, ms scaled by 10
	function integer dly(input [7:0] r);
		dly = (r[2:0] == 3'h7 ? 175 : r[2:0] * 25) * 10;
	endfunction
	task stop_test;
		begin
			$display("compares %0d mismatches %0d", cmp_count, failures);
			if (failures == 0 && cmp_count > 0)
				$display("ALL CHECKS OK");
			else
				$display("CHECKS NOT OK");
			$finish;
		end
	endtask

	////////////////////////////////////////
	// main sequence
	initial begin
		w = $urandom(48);
		cyc(3);
		sys_rst <= 1'b0;
		rd(8'h50, 16'h00BC);
		rd(8'h4F, 16'h007D);
		// wrong page and unknown code refused
		i_tfm_host_model.xfer(1'b1, 8'h01, 8'h51, 16'h0005);
		chk(i_tfm_host_model.ok, 1'b0, "page");
		i_tfm_host_model.xfer(1'b0, 8'h00, 8'h52, 16'h0000);
		chk(i_tfm_host_model.rdat, 16'h0000, "code");
		rd(8'h51, 16'h006E);
		rd(8'h53, 16'hFFD8);
		// random thresholds kept clear of room temperature
		for (i = 0; i < 4; i = i + 1) begin
			v = $urandom % 71 + 30;
			u = $urandom % 71;
			u = u - 50;
			wr(8'h51, v[15:0]);
			wr(8'h53, u[15:0]);
			rd(8'h51, v[15:0]);
			rd(8'h53, u[15:0]);
		end
		tmp(v[15:0]);
		chk(temp_status[6], 1'b0, "warn");
		tmp(v[15:0] + 16'h0001);
		chk({temp_status[6], alert_output_n}, 2'b10, "warn");
		tmp(u[15:0] - 16'h0001);
		chk(temp_status[4], 1'b1, "under");
		// a hot value without its strobe is ignored
		cyc(1);
		temp_valid <= 1'b0;
		tmp(16'h00C8);
		chk(temp_status[7], 1'b0, "valid");
		cyc(1);
		temp_valid <= 1'b1;
		temp_sample <= 16'h0019;
		// warning out of reach so the alert below comes from the fault alone
		wr(8'h51, 16'h0096);
		// every response kind against a fault
		for (i = 0; i < 7; i = i + 1) begin
			c = tab[55 - 8 * i -: 8];
			tmp(16'h0019);
			tmp(16'h0019);
			chk({alert_output_n, temp_status}, {1'b1, 8'h00}, "clear");
			rail_on_cmd <= 1'b0;
			cyc(2);
			rail_on_cmd <= 1'b1;
			wr(8'h50, {8'h00, c});
			cyc(3);
			chk(output_enable, 1'b1, "oe");
			tmp(16'h007E);
			chk({alert_output_n, temp_status[7]}, 2'b01, "alert");
			rd(8'h7D, 16'h0080);
			chk(output_enable, c[7:6] != 2'b10, "oe");
			// four degrees under is still a fault
			tmp(16'h0079);
			cyc(25);
			chk(output_enable, c[7:6] != 2'b10, "hyst");
			cyc(1);
			temp_sample <= 16'h0078;
			n = 0;
			while (!output_enable && n < 3000) begin
				cyc(1);
				n = n + 1;
			end
			if (c[7:6] != 2'b10)
				chk(n, 0, "run");
			else if (c[5:3] == 3'h0)
				chk(n, 3000, "latch");
			else
				chk(n + 50 >= dly(c) && n <= dly(c) + 8, 1'b1, "retry");
		end
		cyc(1);
		other_fault_off <= 1'b1;
		cyc(3);
		chk(output_enable, 1'b0, "other");
		stop_test;
	end

	// watchdog well past the expected run
	initial begin
		#300000;
		failures = failures + 1;
		stop_test;
	end
endmodule

bind tfm_temp_fault tfm_assertions #(.MS_CYCLES(MS_CYCLES)) i_tfm_assertions(.ref_clk, .sys_rst, .reg_wr,
	.reg_rd, .reg_page, .reg_ack, .reg_nack, .temp_valid, .rail_on_cmd, .other_fault_off, .output_enable,
	.alert_output_n, .temp_status);

/* tb/tfm_assertions.sv */
/* port checker for tfm_temp_fault; assumes a bind into it */
`timescale 1ns/1ps
module tfm_assertions #(
	parameter MS_CYCLES = 10
) (
	// clock and reset
	input wire       ref_clk,
	input wire       sys_rst,
	// register port
	input wire       reg_wr,
	input wire       reg_rd,
	input wire [7:0] reg_page,
	input wire       reg_ack,
	input wire       reg_nack,
	// temperature and rail
	input wire       temp_valid,
	input wire       rail_on_cmd,
	input wire       other_fault_off,
	input wire       output_enable,
	input wire       alert_output_n,
	input wire [7:0] temp_status
);
	// one domain, quiet in reset
	default clocking @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	chk_answer_next: assert property ((reg_wr || reg_rd) |=> reg_ack ^ reg_nack)
		else $error("no single answer");
	chk_page_refused: assert property ((reg_wr || reg_rd) && reg_page != 8'h00 |=> reg_nack)
		else $error("bad page kept");
	chk_answer_cause: assert property (reg_ack || reg_nack |-> $past(reg_wr || reg_rd))
		else $error("answer unasked");
	chk_alert_ot: assert property (temp_status[7] |-> !alert_output_n)
		else $error("fault without alert");
	chk_ot_cause: assert property ($rose(temp_status[7]) |-> $past(temp_valid))
		else $error("fault without sample");
	chk_alert_cause: assert property ($fell(alert_output_n) |-> temp_status != 8'h00)
		else $error("alert without status");
	chk_enable_cause: assert property ($rose(output_enable) |-> $past(rail_on_cmd && !other_fault_off))
		else $error("output on unasked");
	chk_other_off: assert property (other_fault_off [*2] |=> !output_enable)
		else $error("output on in fault");
endmodule

/* tb/tfm_host_model.sv */
/* host model on the register port; assumes ref_clk of the bench */
`timescale 1ns/1ps
module tfm_host_model (
	// clock
	input  wire        ref_clk,
	// register port
	output reg         reg_wr = 1'b0,
	output reg         reg_rd = 1'b0,
	output reg  [7:0]  reg_page = 8'h00,
	output reg  [7:0]  reg_cmd = 8'h00,
	output reg  [15:0] reg_wdata = 16'h0000,
	input  wire [15:0] reg_rdata,
	input  wire        reg_ack,
	input  wire        reg_nack
);
	reg        ok;
	reg [15:0] rdat;
	task xfer(input w, input [7:0] pg, input [7:0] cmd, input [15:0] d);
		begin
			@(posedge ref_clk);
			{reg_wr, reg_rd, reg_page, reg_cmd, reg_wdata} <= {w, !w, pg, cmd, d};
			@(posedge ref_clk);
			{reg_wr, reg_rd, reg_wdata} <= {2'b00, ~d}; // stale data inverted
			// answer taken at the edge where ack or nack stands
			@(posedge ref_clk);
			ok = reg_ack && !reg_nack;
			rdat = reg_rdata;
		end
	endtask
endmodule
